//--- hdl/sal_top.sv
// Service-data request checker with abort coding, and process-data length/state limiter.
// Assumes dictionary attributes arrive on the same clock, valid together with req_valid.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Reply buffer
module sal_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wptr_q;
	logic [AW:0] rptr_q;
	logic full;
	logic empty;

	assign full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
	assign empty = (wptr_q == rptr_q);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_q[rptr_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem_q[wptr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (in_valid && !full) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (out_ready && !empty) begin
				rptr_q <= rptr_q + 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top
// Contract
// - Failed requests answer with a 32-bit reason code in the data bytes.
// - Unflipped toggle bit in a segment aborts with 05030000.
// - Unknown command specifier in byte zero aborts with 05040001.
// - Writes to constant or read-only entries abort with 06010002.
// - Access to a nonexistent index aborts with 06020000.
// - Mapping a non-mappable object aborts with 06040041.
// - Mapping past eight payload bytes aborts with 06040042.
// - Write longer than the object type aborts with 06070012.
// - Write shorter than the object type aborts with 06070013.
// - Existing index with invalid subindex aborts with 06090011.
// - Ranged write above maximum aborts with 06090031.
// - Error history count subentry accepts only zero, else value-too-large.
// - Ranged write below minimum aborts with 06090032.
// - Anything else failing aborts with general code 08000000.
// - Process-data parameter writes abort with 08000022 while operational.
// - Process-data frames hold payload only; meaning comes from stored mapping.
// - Process data is exchanged only in the operational state.
// - Eight receive and eight transmit process-data mappings are stored.
// - At most eight bytes of mapped data per process-data frame.
// - Frame length follows the total size of mapped objects.
// - Abort frame: 0x80, index, subindex, then reason code in bytes 4-7.
// - Received abort ends the transfer unconfirmed; restart from initiation.
// - Toggle bit starts at zero in every new segmented transfer.
module sal_top import sal_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [63:0] req_data,
	input wire sal_nmt_t nmt_state,
	input wire logic od_idx_ok,
	input wire logic od_sub_ok,
	input wire logic od_read_only,
	input wire logic [7:0] od_size,
	input wire logic od_ranged,
	input wire logic [31:0] od_min,
	input wire logic [31:0] od_max,
	input wire logic od_tgt_mappable,
	input wire logic [31:0] od_rd_data,
	input wire logic [55:0] od_seg_data,
	output logic od_wr_en,
	output logic [15:0] od_wr_idx,
	output logic [7:0] od_wr_sub,
	output logic [31:0] od_wr_data,
	output logic rep_valid,
	input wire logic rep_ready,
	output logic [63:0] rep_data,
	input wire logic pdo_in_valid,
	input wire logic [2:0] pdo_sel,
	input wire logic [63:0] pdo_in_data,
	output logic pdo_out_valid,
	output logic [3:0] pdo_out_len,
	output logic [63:0] pdo_out_data,
	output logic pdo_drop
);

	sal_xfer_t xfer_q;
	logic toggle_q;
	logic [7:0] left_q;
	logic [15:0] cur_idx_q;
	logic [7:0] cur_sub_q;
	logic [6:0] map_bits_q [2*SAL_MAP_COUNT];

	logic fire;
	logic [2:0] ccs;
	logic [7:0] cmd;
	logic [15:0] idx;
	logic [7:0] sub;
	logic [31:0] val;
	logic [15:0] grp;
	logic is_pdo_par;
	logic is_map;
	logic [3:0] map_sel;
	logic [2:0] exp_len;
	logic [31:0] val_m;
	logic [8:0] map_sum;
	logic [7:0] seg_bytes;
	logic [7:0] up_bytes;
	logic up_last;
	logic abort;
	logic [31:0] code;
	logic [63:0] ok_frame;
	logic [63:0] rep_frame;
	logic push;
	logic push_ready;

	////////////////////////////////////////////////////////////////////////////
	// Request decode
	assign cmd = req_data[7:0];
	assign idx = req_data[23:8];
	assign sub = req_data[31:24];
	assign val = req_data[63:32];
	assign ccs = cmd[7:5];
	assign fire = req_valid && req_ready;
	assign req_ready = push_ready;
	assign grp = idx & SAL_IDX_GROUP_MASK;
	assign is_pdo_par = (grp == SAL_IDX_RX_COMM) || (grp == SAL_IDX_RX_MAP) || (grp == SAL_IDX_TX_COMM)
		|| (grp == SAL_IDX_TX_MAP);
	assign is_map = (grp == SAL_IDX_RX_MAP) || (grp == SAL_IDX_TX_MAP);
	assign map_sel = {idx[SAL_IDX_DIR_BIT], idx[2:0]};
	assign exp_len = SAL_EXP_MAX_BYTES - {1'b0, cmd[3:2]};
	assign map_sum = {2'b00, map_bits_q[map_sel]} + {1'b0, val[7:0]};
	assign seg_bytes = SAL_SEG_MAX_BYTES - {5'h00, cmd[3:1]};
	assign up_bytes = (left_q > SAL_SEG_MAX_BYTES) ? SAL_SEG_MAX_BYTES : left_q;
	assign up_last = (left_q <= SAL_SEG_MAX_BYTES);

	always_comb begin
		case (exp_len)
			3'h1: val_m = {24'h000000, val[7:0]};
			3'h2: val_m = {16'h0000, val[15:0]};
			3'h3: val_m = {8'h00, val[23:0]};
			default: val_m = val;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Abort selection, highest priority first
	always_comb begin
		abort = 1'b0;
		code = 32'h00000000;
		case (ccs)
			SAL_CCS_DN_INIT, SAL_CCS_UP_INIT: begin
				abort = 1'b1;
				if (!od_idx_ok) begin
					code = SAL_AB_NO_OBJECT;
				end else if (!od_sub_ok) begin
					code = SAL_AB_NO_SUBINDEX;
				end else if (ccs == SAL_CCS_UP_INIT) begin
					abort = 1'b0;
				end else if (od_read_only) begin
					code = SAL_AB_READ_ONLY;
				end else if (is_pdo_par && nmt_state == SAL_NMT_OPER) begin
					code = SAL_AB_BAD_STATE;
				end else if (is_map && sub != 8'h00 && !od_tgt_mappable) begin
					code = SAL_AB_NOT_MAPPABLE;
				end else if (is_map && sub != 8'h00 && map_sum > SAL_PDO_MAX_BITS) begin
					code = SAL_AB_MAP_OVERFLOW;
				end else if (cmd[SAL_SIZE_BIT] && (cmd[SAL_EXP_BIT] ? {5'h00, exp_len} > od_size
						: val > {24'h000000, od_size})) begin
					code = SAL_AB_TOO_LONG;
				end else if (cmd[SAL_SIZE_BIT] && (cmd[SAL_EXP_BIT] ? {5'h00, exp_len} < od_size
						: val < {24'h000000, od_size})) begin
					code = SAL_AB_TOO_SHORT;
				end else if (cmd[SAL_EXP_BIT] && idx == SAL_IDX_ERR_HISTORY && sub == 8'h00
						&& val_m != 32'h00000000) begin
					code = SAL_AB_VALUE_HIGH;
				end else if (cmd[SAL_EXP_BIT] && od_ranged && val_m > od_max) begin
					code = SAL_AB_VALUE_HIGH;
				end else if (cmd[SAL_EXP_BIT] && od_ranged && val_m < od_min) begin
					code = SAL_AB_VALUE_LOW;
				end else begin
					abort = 1'b0;
				end
			end
			SAL_CCS_DN_SEG, SAL_CCS_UP_SEG: begin
				abort = 1'b1;
				if (xfer_q != ((ccs == SAL_CCS_DN_SEG) ? SAL_XF_DOWN : SAL_XF_UP)) begin
					code = SAL_AB_GENERAL;
				end else if (cmd[SAL_TOGGLE_BIT] != toggle_q) begin
					code = SAL_AB_TOGGLE;
				end else if (ccs == SAL_CCS_DN_SEG && seg_bytes > left_q) begin
					code = SAL_AB_TOO_LONG;
				end else if (ccs == SAL_CCS_DN_SEG && cmd[SAL_MORE_BIT] && seg_bytes < left_q) begin
					code = SAL_AB_TOO_SHORT;
				end else begin
					abort = 1'b0;
				end
			end
			SAL_CCS_ABORT: begin
				abort = 1'b0;
			end
			default: begin
				abort = 1'b1;
				code = SAL_AB_UNKNOWN_CMD;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Reply frame
	always_comb begin
		case (ccs)
			SAL_CCS_DN_INIT: ok_frame = {32'h00000000, sub, idx, SAL_CMD_DN_ACK};
			SAL_CCS_UP_INIT: begin
				if (od_size <= {5'h00, SAL_EXP_MAX_BYTES}) begin
					ok_frame = {od_rd_data, sub, idx, SAL_CMD_UP_EXP,
						2'(SAL_EXP_MAX_BYTES - od_size[2:0]), 2'b11};
				end else begin
					ok_frame = {24'h000000, od_size, sub, idx, SAL_CMD_UP_SIZED};
				end
			end
			SAL_CCS_DN_SEG: ok_frame = {56'h0, SAL_CMD_DN_SEG_ACK, toggle_q, 4'h0};
			default: ok_frame = {od_seg_data & ~(56'hffffffffffffff << {up_bytes[2:0], 3'h0}),
				SAL_CMD_UP_SEG, toggle_q, 3'(SAL_SEG_MAX_BYTES[2:0] - up_bytes[2:0]), up_last};
		endcase
		if (abort) begin
			if (ccs == SAL_CCS_DN_SEG || ccs == SAL_CCS_UP_SEG) begin
				rep_frame = {code, cur_sub_q, cur_idx_q, SAL_CMD_ABORT};
			end else begin
				rep_frame = {code, sub, idx, SAL_CMD_ABORT};
			end
		end else begin
			rep_frame = ok_frame;
		end
	end

	assign push = req_valid && (ccs != SAL_CCS_ABORT);

	sal_fifo #(
		.WIDTH(SAL_FRAME_W),
		.DEPTH(SAL_FIFO_DEPTH)
	) u_reply_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(push_ready),
		.in_data(rep_frame),
		.out_valid(rep_valid),
		.out_ready(rep_ready),
		.out_data(rep_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Transfer state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_q <= SAL_XF_IDLE;
			toggle_q <= 1'b0;
			left_q <= 8'h00;
			cur_idx_q <= 16'h0000;
			cur_sub_q <= 8'h00;
		end else if (fire) begin
			if (abort || ccs == SAL_CCS_ABORT) begin
				xfer_q <= SAL_XF_IDLE;
			end else if (ccs == SAL_CCS_DN_INIT || ccs == SAL_CCS_UP_INIT) begin
				cur_idx_q <= idx;
				cur_sub_q <= sub;
				toggle_q <= 1'b0;
				if (ccs == SAL_CCS_DN_INIT && !cmd[SAL_EXP_BIT]) begin
					xfer_q <= SAL_XF_DOWN;
					left_q <= cmd[SAL_SIZE_BIT] ? val[7:0] : od_size;
				end else if (ccs == SAL_CCS_UP_INIT && od_size > {5'h00, SAL_EXP_MAX_BYTES}) begin
					xfer_q <= SAL_XF_UP;
					left_q <= od_size;
				end else begin
					xfer_q <= SAL_XF_IDLE;
				end
			end else if (ccs == SAL_CCS_DN_SEG) begin
				toggle_q <= !toggle_q;
				left_q <= left_q - seg_bytes;
				if (cmd[SAL_MORE_BIT]) begin
					xfer_q <= SAL_XF_IDLE;
				end
			end else if (ccs == SAL_CCS_UP_SEG) begin
				toggle_q <= !toggle_q;
				left_q <= left_q - up_bytes;
				if (up_last) begin
					xfer_q <= SAL_XF_IDLE;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Dictionary write strobe for accepted expedited writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			od_wr_en <= 1'b0;
			od_wr_idx <= 16'h0000;
			od_wr_sub <= 8'h00;
			od_wr_data <= 32'h00000000;
		end else begin
			od_wr_en <= fire && !abort && ccs == SAL_CCS_DN_INIT && cmd[SAL_EXP_BIT];
			if (fire && ccs == SAL_CCS_DN_INIT) begin
				od_wr_idx <= idx;
				od_wr_sub <= sub;
				od_wr_data <= val_m;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mapped size per mapping
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2*SAL_MAP_COUNT; i++) begin
				map_bits_q[i] <= 7'h00;
			end
		end else if (fire && !abort && ccs == SAL_CCS_DN_INIT && cmd[SAL_EXP_BIT] && is_map) begin
			if (sub == 8'h00) begin
				if (val[7:0] == 8'h00) begin
					map_bits_q[map_sel] <= 7'h00;
				end
			end else begin
				map_bits_q[map_sel] <= map_sum[6:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Process-data output
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pdo_out_valid <= 1'b0;
			pdo_out_len <= 4'h0;
			pdo_out_data <= 64'h0;
			pdo_drop <= 1'b0;
		end else begin
			pdo_out_valid <= pdo_in_valid && nmt_state == SAL_NMT_OPER;
			pdo_drop <= pdo_in_valid && nmt_state != SAL_NMT_OPER;
			if (pdo_in_valid) begin
				pdo_out_len <= 4'((map_bits_q[{1'b1, pdo_sel}] + 7'h07) >> 3);
				pdo_out_data <= pdo_in_data & ~(64'hffffffffffffffff << map_bits_q[{1'b1, pdo_sel}]);
			end
		end
	end

endmodule

//--- hdl/sal_pkg.sv
// Constants and types for the service-data checker and process-data limiter.
// Assumes little-endian 8-byte frames with byte 0 in bits 7:0.
package sal_pkg;

	localparam int SAL_FRAME_W = 64;
	localparam int SAL_FIFO_DEPTH = 32;
	localparam int SAL_MAP_COUNT = 8;

	// Client command specifiers, bits 7:5 of byte 0
	localparam logic [2:0] SAL_CCS_DN_SEG = 3'h0;
	localparam logic [2:0] SAL_CCS_DN_INIT = 3'h1;
	localparam logic [2:0] SAL_CCS_UP_INIT = 3'h2;
	localparam logic [2:0] SAL_CCS_UP_SEG = 3'h3;
	localparam logic [2:0] SAL_CCS_ABORT = 3'h4;

	// Command byte fields
	localparam int SAL_TOGGLE_BIT = 4;
	localparam int SAL_EXP_BIT = 1;
	localparam int SAL_SIZE_BIT = 0;
	localparam int SAL_MORE_BIT = 0;

	// Server command bytes
	localparam logic [7:0] SAL_CMD_ABORT = 8'h80;
	localparam logic [7:0] SAL_CMD_DN_ACK = 8'h60;
	localparam logic [2:0] SAL_CMD_DN_SEG_ACK = 3'h1;
	localparam logic [7:0] SAL_CMD_UP_SIZED = 8'h41;
	localparam logic [3:0] SAL_CMD_UP_EXP = 4'h4;
	localparam logic [2:0] SAL_CMD_UP_SEG = 3'h0;

	// Abort reason codes
	localparam logic [31:0] SAL_AB_TOGGLE = 32'h05030000;
	localparam logic [31:0] SAL_AB_UNKNOWN_CMD = 32'h05040001;
	localparam logic [31:0] SAL_AB_READ_ONLY = 32'h06010002;
	localparam logic [31:0] SAL_AB_NO_OBJECT = 32'h06020000;
	localparam logic [31:0] SAL_AB_NOT_MAPPABLE = 32'h06040041;
	localparam logic [31:0] SAL_AB_MAP_OVERFLOW = 32'h06040042;
	localparam logic [31:0] SAL_AB_TOO_LONG = 32'h06070012;
	localparam logic [31:0] SAL_AB_TOO_SHORT = 32'h06070013;
	localparam logic [31:0] SAL_AB_NO_SUBINDEX = 32'h06090011;
	localparam logic [31:0] SAL_AB_VALUE_HIGH = 32'h06090031;
	localparam logic [31:0] SAL_AB_VALUE_LOW = 32'h06090032;
	localparam logic [31:0] SAL_AB_GENERAL = 32'h08000000;
	localparam logic [31:0] SAL_AB_BAD_STATE = 32'h08000022;

	// Dictionary indices
	localparam logic [15:0] SAL_IDX_ERR_HISTORY = 16'h1003;
	localparam logic [15:0] SAL_IDX_RX_COMM = 16'h1400;
	localparam logic [15:0] SAL_IDX_RX_MAP = 16'h1600;
	localparam logic [15:0] SAL_IDX_TX_COMM = 16'h1800;
	localparam logic [15:0] SAL_IDX_TX_MAP = 16'h1a00;
	localparam logic [15:0] SAL_IDX_GROUP_MASK = 16'hfff8;
	localparam int SAL_IDX_DIR_BIT = 11;

	// Process-data and service-data frame limits
	localparam logic [8:0] SAL_PDO_MAX_BITS = 9'h040;
	localparam logic [2:0] SAL_EXP_MAX_BYTES = 3'h4;
	localparam logic [7:0] SAL_SEG_MAX_BYTES = 8'h07;

	typedef enum logic [1:0] {SAL_NMT_STOPPED, SAL_NMT_PREOP, SAL_NMT_OPER, SAL_NMT_INIT} sal_nmt_t;
	typedef enum logic [1:0] {SAL_XF_IDLE, SAL_XF_DOWN, SAL_XF_UP} sal_xfer_t;

endpackage

//--- verification/sal_monitor.sv
// Port checks for sal_top: replies, aborts, state gating of process data.
// Assumes one clock domain and attachment by bind onto sal_top.
`timescale 1ns/1ps
module sal_monitor import sal_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [63:0] req_data,
	input wire sal_nmt_t nmt_state,
	input wire logic od_wr_en,
	input wire logic rep_valid,
	input wire logic rep_ready,
	input wire logic [63:0] rep_data,
	input wire logic pdo_in_valid,
	input wire logic pdo_out_valid,
	input wire logic [3:0] pdo_out_len,
	input wire logic [63:0] pdo_out_data,
	input wire logic pdo_drop
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic pdo_par;
	assign pdo_par = (req_data[23:8] & SAL_IDX_GROUP_MASK) inside {SAL_IDX_RX_COMM, SAL_IDX_RX_MAP,
		SAL_IDX_TX_COMM, SAL_IDX_TX_MAP};
	sequence s_take;
		req_valid && req_ready && !rep_valid;
	endsequence
	sequence s_abort_in;
		s_take ##0 req_data[7:0] == SAL_CMD_ABORT;
	endsequence
	sequence s_plain_in;
		s_take ##0 req_data[7:0] != SAL_CMD_ABORT;
	endsequence
	AST_REPLY_NEXT: assert property (s_plain_in |=> rep_valid)
		else $error("no reply after request");
	AST_REPLY_HOLD: assert property (rep_valid && !rep_ready |=> rep_valid && $stable(rep_data))
		else $error("reply dropped before accept");
	AST_ABORT_SILENT: assert property (s_abort_in |=> !rep_valid)
		else $error("reply to abort frame");
	AST_PAR_OPER: assert property (req_valid && req_ready && nmt_state == SAL_NMT_OPER && pdo_par
		&& req_data[7:5] == SAL_CCS_DN_INIT |=> !od_wr_en) else $error("parameter written while operational");
	AST_PDO_DROP: assert property (pdo_in_valid && nmt_state != SAL_NMT_OPER |=> pdo_drop && !pdo_out_valid)
		else $error("frame passed outside operational");
	AST_PDO_PASS: assert property (pdo_in_valid && nmt_state == SAL_NMT_OPER |=> pdo_out_valid && !pdo_drop)
		else $error("frame lost while operational");
	AST_PDO_LEN: assert property (pdo_out_valid |-> pdo_out_len <= 4'h8)
		else $error("frame longer than eight bytes");
	AST_PDO_TAIL: assert property (pdo_out_valid && pdo_out_len < 4'h8 |->
		(pdo_out_data >> {pdo_out_len, 3'h0}) == 64'h0) else $error("bytes beyond length not zero");
endmodule

bind sal_top sal_monitor sal_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
	.req_ready(req_ready), .req_data(req_data), .nmt_state(nmt_state), .od_wr_en(od_wr_en),
	.rep_valid(rep_valid), .rep_ready(rep_ready), .rep_data(rep_data), .pdo_in_valid(pdo_in_valid),
	.pdo_out_valid(pdo_out_valid), .pdo_out_len(pdo_out_len), .pdo_out_data(pdo_out_data), .pdo_drop(pdo_drop));

//--- verification/sal_master_model.sv
// Master model: offers service-data frames and takes replies.
// Assumes the bench calls send and get; signals move at the falling edge.
`timescale 1ns/1ps
module sal_master_model (
	input wire logic ref_clk,
	input wire logic req_ready,
	input wire logic rep_valid,
	input wire logic [63:0] rep_data,
	output logic req_valid,
	output logic [63:0] req_data,
	output logic rep_ready
);
	initial begin
		req_valid = 1'b0;
		req_data = 64'h0;
		rep_ready = 1'b0;
	end
	// Frame held until taken
	task automatic send(input logic [63:0] f);
		int k;
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_data = f;
		k = 0;
		while (req_ready !== 1'b1 && k < 200) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= 200) sal_top_tb.fails++;
		@(posedge ref_clk);
		@(negedge ref_clk);
		req_valid = 1'b0;
		req_data = ~f;
	endtask
	// Reply taken after optional stall
	task automatic get(output logic [63:0] f, input int stall);
		int k;
		repeat (stall + 1) @(negedge ref_clk);
		rep_ready = 1'b1;
		k = 0;
		while (rep_valid !== 1'b1 && k < 200) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= 200) sal_top_tb.fails++;
		f = rep_data;
		@(negedge ref_clk);
		rep_ready = 1'b0;
	endtask
endmodule

//--- verification/sal_top_tb.sv
// Self-checking bench for sal_top.
// Assumes sal_master_model on the request side and sal_monitor bound in.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, a, e); end end
module sal_top_tb import sal_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n, req_valid, req_ready, rep_valid, rep_ready, od_idx_ok, od_sub_ok, od_read_only, od_ranged;
	logic od_tgt_mappable, od_wr_en, pdo_in_valid, pdo_out_valid, pdo_drop;
	logic [63:0] req_data, rep_data, pdo_in_data, pdo_out_data, r;
	logic [31:0] od_min, od_max, od_rd_data, od_wr_data;
	logic [55:0] od_seg_data;
	logic [15:0] od_wr_idx;
	logic [7:0] od_size, od_wr_sub;
	logic [3:0] pdo_out_len;
	logic [2:0] pdo_sel;
	sal_nmt_t nmt_state;
	int fails = 0;
	int checked = 0;
	int wr_cnt = 0;
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (od_wr_en === 1'b1) wr_cnt++;
	sal_top sal_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
		.req_data(req_data), .nmt_state(nmt_state), .od_idx_ok(od_idx_ok), .od_sub_ok(od_sub_ok),
		.od_read_only(od_read_only), .od_size(od_size), .od_ranged(od_ranged), .od_min(od_min), .od_max(od_max),
		.od_tgt_mappable(od_tgt_mappable), .od_rd_data(od_rd_data), .od_seg_data(od_seg_data), .od_wr_en(od_wr_en),
		.od_wr_idx(od_wr_idx), .od_wr_sub(od_wr_sub), .od_wr_data(od_wr_data), .rep_valid(rep_valid),
		.rep_ready(rep_ready), .rep_data(rep_data), .pdo_in_valid(pdo_in_valid), .pdo_sel(pdo_sel),
		.pdo_in_data(pdo_in_data), .pdo_out_valid(pdo_out_valid), .pdo_out_len(pdo_out_len),
		.pdo_out_data(pdo_out_data), .pdo_drop(pdo_drop));
	sal_master_model sal_master_model_i (.ref_clk(ref_clk), .req_ready(req_ready), .rep_valid(rep_valid),
		.rep_data(rep_data), .req_valid(req_valid), .req_data(req_data), .rep_ready(rep_ready));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [63:0] f(logic [7:0] c, logic [15:0] ix, logic [7:0] sb, logic [31:0] v);
		return {v, sb, ix, c};
	endfunction
	task automatic od(input logic ix, sb, ro, rg, mp, input logic [7:0] sz);
		@(negedge ref_clk);
		od_idx_ok = ix;
		od_sub_ok = sb;
		od_read_only = ro;
		od_ranged = rg;
		od_tgt_mappable = mp;
		od_size = sz;
	endtask
	task automatic xfer(input logic [63:0] q);
		sal_master_model_i.send(q);
		sal_master_model_i.get(r, 0);
	endtask
	task automatic ab(input logic [7:0] c, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v, code);
		xfer(f(c, ix, sb, v));
		`CHK(r, f(SAL_CMD_ABORT, ix, sb, code))
	endtask
	task automatic pdo(input logic [2:0] s, input logic ok, input logic [3:0] n, input logic [63:0] d);
		@(negedge ref_clk);
		pdo_in_valid = 1'b1;
		pdo_sel = s;
		@(negedge ref_clk);
		pdo_in_valid = 1'b0;
		`CHK({pdo_out_valid, pdo_drop}, {ok, !ok})
		if (ok) `CHK({pdo_out_len, pdo_out_data}, {n, d})
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_lookup;
		od(0, 0, 0, 0, 1, 8'h04);
		ab(8'h23, 16'h2000, 8'h00, 32'h5, SAL_AB_NO_OBJECT);
		od(1, 0, 1, 0, 1, 8'h04);
		ab(8'h23, 16'h2000, 8'h09, 32'h5, SAL_AB_NO_SUBINDEX);
		od(1, 1, 1, 0, 1, 8'h04);
		ab(8'h23, 16'h2000, 8'h01, 32'h5, SAL_AB_READ_ONLY);
		od(1, 1, 0, 0, 1, 8'h01);
		ab(8'h23, 16'h2000, 8'h01, 32'h5, SAL_AB_TOO_LONG);
		od(1, 1, 0, 0, 1, 8'h04);
		ab(8'h2f, 16'h2000, 8'h01, 32'h5, SAL_AB_TOO_SHORT);
		for (int c = 5; c < 8; c++) ab({c[2:0], 5'h0}, 16'h2000, 8'h01, 32'h0, SAL_AB_UNKNOWN_CMD);
	endtask
	task automatic t_range;
		int n0;
		n0 = wr_cnt;
		od(1, 1, 0, 1, 1, 8'h04);
		ab(8'h23, 16'h2001, 8'h00, 32'd101, SAL_AB_VALUE_HIGH);
		ab(8'h23, 16'h2001, 8'h00, 32'd9, SAL_AB_VALUE_LOW);
		xfer(f(8'h23, 16'h2001, 8'h00, 32'd100));
		`CHK(r, f(SAL_CMD_DN_ACK, 16'h2001, 8'h00, 32'h0))
		`CHK(wr_cnt - n0, 1)
		`CHK({od_wr_idx, od_wr_sub, od_wr_data}, {16'h2001, 8'h00, 32'd100})
		od(1, 1, 0, 0, 1, 8'h01);
		ab(8'h2f, SAL_IDX_ERR_HISTORY, 8'h00, 32'h1, SAL_AB_VALUE_HIGH);
		xfer(f(8'h2f, SAL_IDX_ERR_HISTORY, 8'h00, 32'h0));
		`CHK(r, f(SAL_CMD_DN_ACK, SAL_IDX_ERR_HISTORY, 8'h00, 32'h0))
	endtask
	task automatic t_par;
		logic [15:0] base [4] = '{SAL_IDX_RX_COMM, SAL_IDX_RX_MAP, SAL_IDX_TX_COMM, SAL_IDX_TX_MAP};
		od(1, 1, 0, 0, 1, 8'h04);
		nmt_state = SAL_NMT_OPER;
		for (int i = 0; i < 4; i++) ab(8'h23, base[i] | 16'h7, 8'h02, 32'hff, SAL_AB_BAD_STATE);
		nmt_state = SAL_NMT_STOPPED;
		xfer(f(8'h23, 16'h1807, 8'h02, 32'hff));
		`CHK(r, f(SAL_CMD_DN_ACK, 16'h1807, 8'h02, 32'h0))
	endtask
	task automatic t_map;
		od(1, 1, 0, 0, 1, 8'h04);
		nmt_state = SAL_NMT_PREOP;
		xfer(f(8'h23, 16'h1a00, 8'h01, 32'h60400020));
		xfer(f(8'h23, 16'h1a00, 8'h02, 32'h607a0020));
		`CHK(r, f(SAL_CMD_DN_ACK, 16'h1a00, 8'h02, 32'h0))
		ab(8'h23, 16'h1a00, 8'h03, 32'h60410008, SAL_AB_MAP_OVERFLOW);
		xfer(f(8'h23, 16'h1a01, 8'h01, 32'h60410010));
		od(1, 1, 0, 0, 0, 8'h04);
		ab(8'h23, 16'h1a01, 8'h02, 32'h10000020, SAL_AB_NOT_MAPPABLE);
		pdo(3'h0, 1'b0, 4'h0, 64'h0);
		nmt_state = SAL_NMT_OPER;
		pdo(3'h0, 1'b1, 4'h8, '1);
		pdo(3'h1, 1'b1, 4'h2, 64'hffff);
		pdo(3'h2, 1'b1, 4'h0, 64'h0);
	endtask
	task automatic t_seg;
		od(1, 1, 0, 0, 1, 8'd10);
		nmt_state = SAL_NMT_PREOP;
		xfer(f(8'h40, 16'h2002, 8'h00, 32'h0));
		`CHK(r, f(SAL_CMD_UP_SIZED, 16'h2002, 8'h00, 32'd10))
		xfer(f(8'h60, 16'h2002, 8'h00, 32'h0));
		`CHK(r, {od_seg_data, 8'h00})
		ab(8'h60, 16'h2002, 8'h00, 32'h0, SAL_AB_TOGGLE);
		ab(8'h60, 16'h2002, 8'h00, 32'h0, SAL_AB_GENERAL);
		xfer(f(8'h40, 16'h2002, 8'h00, 32'h0));
		ab(8'h70, 16'h2002, 8'h00, 32'h0, SAL_AB_TOGGLE);
		xfer(f(8'h40, 16'h2002, 8'h00, 32'h0));
		sal_master_model_i.send(f(SAL_CMD_ABORT, 16'h2002, 8'h00, SAL_AB_GENERAL));
		repeat (4) @(negedge ref_clk);
		`CHK(rep_valid, 1'b0)
		ab(8'h60, 16'h2002, 8'h00, 32'h0, SAL_AB_GENERAL);
		od(1, 1, 0, 0, 1, 8'h02);
		od_rd_data = 32'h00000240;
		xfer(f(8'h40, 16'h6041, 8'h00, 32'h0));
		`CHK(r, f(8'h4b, 16'h6041, 8'h00, 32'h240))
		od(1, 1, 0, 0, 1, 8'd10);
		xfer(f(8'h21, 16'h2003, 8'h00, 32'd10));
		`CHK(r, f(SAL_CMD_DN_ACK, 16'h2003, 8'h00, 32'h0))
		xfer(f(8'h00, 16'h2003, 8'h00, 32'h0));
		`CHK(r, 64'h20)
		ab(8'h17, 16'h2003, 8'h00, 32'h0, SAL_AB_TOO_LONG);
		xfer(f(8'h21, 16'h2003, 8'h00, 32'd10));
		ab(8'h01, 16'h2003, 8'h00, 32'h0, SAL_AB_TOO_SHORT);
	endtask
	task automatic t_fifo;
		od(1, 1, 0, 0, 1, 8'h04);
		for (int i = 0; i < SAL_FIFO_DEPTH; i++) sal_master_model_i.send(f(8'he0, i[15:0], 8'h00, 32'h0));
		`CHK(req_ready, 1'b0)
		for (int i = 0; i < SAL_FIFO_DEPTH; i++) begin
			sal_master_model_i.get(r, i % 3);
			`CHK(r, f(SAL_CMD_ABORT, i[15:0], 8'h00, SAL_AB_UNKNOWN_CMD))
		end
		`CHK(rep_valid, 1'b0)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		results;
	end
	initial begin
		rst_n = 1'b0;
		nmt_state = SAL_NMT_PREOP;
		{od_idx_ok, od_sub_ok, od_read_only, od_ranged, od_tgt_mappable, od_size} = '0;
		od_min = 32'd10;
		od_max = 32'd100;
		od_rd_data = 32'h0;
		od_seg_data = 56'h11223344556677;
		pdo_in_valid = 1'b0;
		pdo_sel = 3'h0;
		pdo_in_data = '1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		t_lookup;
		t_range;
		t_par;
		t_map;
		t_seg;
		t_fifo;
		results;
	end
endmodule
